// ===== relay_output_command_logic.sv
// Operation
// - relay runs latched, unlatched, fixed pulse or toggling pulse mode.
// - inversion energises the output while the relay is logically inactive.
// - unlatched relay follows its setpoints and releases when all are clear.
// - latched relay stays operated until a setpoint or remote release.
// - local release under remote hold clears only the local latch.
// - pulse mode makes one pulse per command; the command self-clears.
// - after a pulse the relay stays released one pulse width.
// - pulse width programmable 10 ms to 1 s, excluding relay times.
// - states evaluated each half cycle, widths round up to half cycles.
// - toggle mode inverts state per command, then holds one pulse width.
// - pulse and toggle modes accept internal energy or interval pulses.
// - remote operate forces latched or unlatched relay active until released.
// - remote release also clears local latch of a latched relay.
// - pulse and toggle relays pulse on remote operate, ignore release.
// - non-retentive relay starts inactive, remote commands discarded.
// - retentive latched relay restores state and remote commands.
// - critical error releases relay and clears remote commands.
module relay_output_command_logic
  import relay_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic clk_i, // 40 MHz clock
  input wire logic nrst_i, // async reset, active low
  input wire logic sample_tick_i, // one pulse per line-locked sample
  input wire logic local_set_i, // setpoint operate level
  input wire logic local_release_i, // setpoint release pulse
  input wire logic pulse_src_i, // internal energy or interval pulse
  input wire logic crit_fault_i, // diagnostics critical error level
  input wire logic nv_retentive_i, // stored retentive flag
  input wire logic nv_latched_i, // stored local latch
  input wire logic nv_remote_i, // stored remote operate flag
  output logic solid_state_relay_output_o, // relay drive, high energises
  output logic relay_state_o, // logical relay state
  output logic remote_flag_o, // remote operate held, for storage
  output logic latch_flag_o, // local latch held, for storage
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  // ==========================================================
  // reset release
  logic rst_meta_r;
  logic rst_n;
  logic boot_r;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      boot_r <= 1'b1;
    else
      boot_r <= 1'b0;
  end
  // ==========================================================
  // timebases
  logic ms_tick;
  logic scan_tick;
  tick_divider #(.DIV(MS_CYCLES)) u_ms_div (
    .clk_i(clk_i),
    .nrst_i(rst_n),
    .en_i(1'b1),
    .tick_o(ms_tick)
  );
  // half-cycle scan follows the measured line frequency
  tick_divider #(.DIV(SAMPLES_PER_HALF)) u_half_div (
    .clk_i(clk_i),
    .nrst_i(rst_n),
    .en_i(sample_tick_i),
    .tick_o(scan_tick)
  );
  // ==========================================================
  // register bus
  logic aw_held_r;
  logic w_held_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  logic [1:0] mode_r;
  logic invert_r;
  logic retain_r;
  logic [9:0] width_r;
  logic rem_op;
  logic rem_rel;
  logic [9:0] width_wr;
  logic [7:0] status;
  pulse_state_type st_r;
  logic pend_r;
  logic remote_r;
  logic latch_r;
  logic state_r;
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign width_wr = w_data_r[9:0];
  assign rem_op = wr_go && (aw_addr_r == CMD_OFS) && w_strb_r[0] && w_data_r[CMD_OPERATE_BIT];
  assign rem_rel = wr_go && (aw_addr_r == CMD_OFS) && w_strb_r[0] && w_data_r[CMD_RELEASE_BIT];
  assign status = {crit_fault_i, st_r, pend_r, latch_r, remote_r,
                   solid_state_relay_output_o, state_r};
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == STATUS_OFS) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          CTRL_OFS: s_axi_rdata <= {28'h0000000, retain_r, invert_r, mode_r};
          WIDTH_OFS: s_axi_rdata <= {22'h000000, width_r};
          CMD_OFS: s_axi_rdata <= 32'h00000000;
          STATUS_OFS: s_axi_rdata <= {24'h000000, status};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // ==========================================================
  // configuration
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= MODE_RST;
      invert_r <= INVERT_RST;
      retain_r <= RETAIN_RST;
      width_r <= WIDTH_RST;
    end
    else if (boot_r)
    begin
      if (nv_retentive_i)
      begin
        mode_r <= MODE_LATCHED;
        retain_r <= 1'b1;
      end
    end
    else if (wr_go && (aw_addr_r == CTRL_OFS) && w_strb_r[0])
    begin
      mode_r <= w_data_r[MODE_LSB +: 2];
      invert_r <= w_data_r[INVERT_BIT];
      retain_r <= w_data_r[RETAIN_BIT];
    end
    else if (wr_go && (aw_addr_r == WIDTH_OFS) && (w_strb_r[1:0] == 2'h3))
    begin
      if (width_wr < PULSE_MIN_MS)
        width_r <= PULSE_MIN_MS;
      else if (width_wr > PULSE_MAX_MS)
        width_r <= PULSE_MAX_MS;
      else
        width_r <= width_wr;
    end
  end
  // ==========================================================
  // command holding
  logic steady_mode;
  logic local_set_d_r;
  logic new_cmd;
  logic take_cmd;
  assign steady_mode = (mode_r == MODE_UNLATCHED) || (mode_r == MODE_LATCHED);
  assign new_cmd = (local_set_i && !local_set_d_r) || pulse_src_i || rem_op;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remote_r <= 1'b0;
      latch_r <= 1'b0;
      local_set_d_r <= 1'b0;
    end
    else if (crit_fault_i)
    begin
      // fault outranks the restore of stored commands
      remote_r <= 1'b0;
      latch_r <= 1'b0;
      local_set_d_r <= local_set_i;
    end
    else if (boot_r)
    begin
      remote_r <= nv_retentive_i && nv_remote_i;
      latch_r <= nv_retentive_i && nv_latched_i;
    end
    else
    begin
      local_set_d_r <= local_set_i;
      if (steady_mode && rem_op)
        remote_r <= 1'b1;
      else if (rem_rel)
        remote_r <= 1'b0;
      if (mode_r != MODE_LATCHED)
        latch_r <= 1'b0;
      else if (local_set_i)
        latch_r <= 1'b1;
      else if (local_release_i || rem_rel)
        latch_r <= 1'b0;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      pend_r <= 1'b0;
    else if (crit_fault_i || steady_mode)
      pend_r <= 1'b0;
    else
      pend_r <= (pend_r && !take_cmd) || new_cmd;
  end
  // ==========================================================
  // relay state machine, evaluated on the half-cycle scan
  logic done;
  logic start;
  assign take_cmd = scan_tick && (st_r == ST_IDLE) && pend_r && !crit_fault_i;
  assign start = take_cmd || (scan_tick && (st_r == ST_ACTIVE) && done && !crit_fault_i);
  pulse_timer u_timer (
    .clk_i(clk_i),
    .nrst_i(rst_n),
    .start_i(start),
    .ms_tick_i(ms_tick),
    .width_i(width_r),
    .done_o(done)
  );
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      state_r <= 1'b0;
    end
    else if (crit_fault_i)
    begin
      st_r <= ST_IDLE;
      state_r <= 1'b0;
    end
    else if (scan_tick)
    begin
      if (steady_mode)
      begin
        st_r <= ST_IDLE;
        if (mode_r == MODE_LATCHED)
          state_r <= latch_r || remote_r;
        else
          state_r <= local_set_i || remote_r;
      end
      else
      begin
        unique case (st_r)
          ST_IDLE:
          begin
            if (pend_r && (mode_r == MODE_PULSE))
            begin
              state_r <= 1'b1;
              st_r <= ST_ACTIVE;
            end
            else if (pend_r)
            begin
              state_r <= !state_r;
              st_r <= ST_HOLD;
            end
          end
          ST_ACTIVE:
          begin
            if (done)
            begin
              state_r <= 1'b0;
              st_r <= ST_HOLD;
            end
          end
          ST_HOLD:
          begin
            if (done)
              st_r <= ST_IDLE;
          end
          default:
          begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
  // ==========================================================
  // outputs
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      solid_state_relay_output_o <= 1'b0;
      relay_state_o <= 1'b0;
      remote_flag_o <= 1'b0;
      latch_flag_o <= 1'b0;
    end
    else
    begin
      solid_state_relay_output_o <= state_r ^ invert_r;
      relay_state_o <= state_r;
      remote_flag_o <= remote_r;
      latch_flag_o <= latch_r;
    end
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);
  a_fault_release: assert property (crit_fault_i |=> !state_r && !remote_r && !pend_r)
    else $error("relay not released on critical fault");
  a_drive_invert: assert property (##1 solid_state_relay_output_o == ($past(state_r) ^ $past(invert_r)))
    else $error("drive does not follow inverted state");
  a_pulse_start: assert property (take_cmd && mode_r == MODE_PULSE |=> state_r && st_r == ST_ACTIVE)
    else $error("pulse not started on accepted command");
  a_toggle_flip: assert property (take_cmd && mode_r == toggle_pulse_mode |=> state_r != $past(state_r))
    else $error("toggle did not invert state");
  a_hold_released: assert property (st_r == ST_HOLD && mode_r == MODE_PULSE && !crit_fault_i |=> !state_r)
    else $error("relay operated during hold-off");
  a_scan_only: assert property (!scan_tick && !crit_fault_i |=> $stable(state_r))
    else $error("relay state changed off scan");
  a_remote_active: assert property (scan_tick && steady_mode && remote_r && !crit_fault_i |=> state_r)
    else $error("remote operate did not hold relay");
  a_local_keep: assert property (local_release_i && remote_r && !rem_rel && !crit_fault_i && !boot_r |=> remote_r)
    else $error("local release cleared remote hold");
  a_width_range: assert property (width_r >= PULSE_MIN_MS && width_r <= PULSE_MAX_MS)
    else $error("pulse width out of range");
  a_unlatch_follow: assert property (scan_tick && mode_r == MODE_UNLATCHED && !local_set_i && !remote_r && !crit_fault_i |=> !state_r)
    else $error("unlatched relay did not release");
  c_pulse_done: cover property (st_r == ST_ACTIVE ##1 st_r == ST_HOLD);
  c_toggle: cover property (take_cmd && mode_r == toggle_pulse_mode);
  c_remote_op: cover property (rem_op && steady_mode);
  c_fault: cover property (state_r ##1 crit_fault_i);
endmodule : relay_output_command_logic

// ===== relay_pkg.sv
package relay_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] WIDTH_OFS = 4'h4;
  localparam logic [3:0] CMD_OFS = 4'h8;
  localparam logic [3:0] STATUS_OFS = 4'hC;
  // ==========================================================
  // field positions
  localparam int MODE_LSB = 0;
  localparam int INVERT_BIT = 2;
  localparam int RETAIN_BIT = 3;
  localparam int CMD_OPERATE_BIT = 0;
  localparam int CMD_RELEASE_BIT = 1;
  // ==========================================================
  // reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic INVERT_RST = 1'b0;
  localparam logic RETAIN_RST = 1'b0;
  localparam logic [9:0] WIDTH_RST = 10'h064;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  localparam int SAMPLES_PER_HALF = 128;
  localparam logic [9:0] PULSE_MIN_MS = 10'd10;
  localparam logic [9:0] PULSE_MAX_MS = 10'd1000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // modes and states
  typedef enum logic [1:0]
  {
    MODE_UNLATCHED = 2'h0,
    MODE_LATCHED = 2'h1,
    MODE_PULSE = 2'h2,
    toggle_pulse_mode = 2'h3
  } mode_type;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_ACTIVE = 2'h1,
    ST_HOLD = 2'h3
  } pulse_state_type;
endpackage : relay_pkg

// ===== tick_divider.sv
module tick_divider #(
  parameter int DIV = 128
) (
  input wire logic clk_i, // clock
  input wire logic nrst_i, // synchronised reset, active low
  input wire logic en_i, // one-cycle count enable
  output logic tick_o // pulse every DIV enables
);
  logic [15:0] cnt_r;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_r <= 16'h0000;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= 1'b0;
      if (en_i)
      begin
        if (cnt_r == 16'(DIV - 1))
        begin
          cnt_r <= 16'h0000;
          tick_o <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end
endmodule : tick_divider

// ===== pulse_timer.sv
module pulse_timer (
  input wire logic clk_i, // clock
  input wire logic nrst_i, // synchronised reset, active low
  input wire logic start_i, // restart timing from zero
  input wire logic ms_tick_i, // one pulse per millisecond
  input wire logic [9:0] width_i, // programmed width, ms
  output logic done_o // width elapsed since start
);
  logic [9:0] ms_r;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ms_r <= 10'h000;
    end
    else if (start_i)
    begin
      ms_r <= 10'h000;
    end
    else if (ms_tick_i && (ms_r != 10'h3FF))
    begin
      ms_r <= ms_r + 10'h001;
    end
  end
  assign done_o = (ms_r >= width_i);
endmodule : pulse_timer

// ===== relay_far_side.sv
// ==========================================================
// load side: watches the contact and times each level
module relay_far_side (
  input wire logic clk_i, // clock
  input wire logic contact_i, // relay drive at the load
  output int rises_o, // energise edges seen
  output int falls_o, // release edges seen
  output int hi_o, // last energised length, cycles
  output int lo_o // last released length, cycles
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_r = 1'b0;
  int run_r = 0;
  int rise_r = 0;
  int fall_r = 0;
  int hi_r = 0;
  int lo_r = 0;
  assign rises_o = rise_r;
  assign falls_o = fall_r;
  assign hi_o = hi_r;
  assign lo_o = lo_r;
  always @(posedge clk_i)
  begin
    last_r <= contact_i;
    run_r <= (contact_i !== last_r) ? 1 : run_r + 1;
    if (contact_i === 1'b1 && last_r === 1'b0)
    begin
      rise_r <= rise_r + 1;
      lo_r <= run_r;
    end
    if (contact_i === 1'b0 && last_r === 1'b1)
    begin
      fall_r <= fall_r + 1;
      hi_r <= run_r;
    end
  end
endmodule : relay_far_side

// ===== relay_output_command_logic_tb.sv
module relay_output_command_logic_tb
  import relay_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SCAN = 256;
  logic clk_i = 1'b0, nrst_i = 1'b0, sample_tick_i = 1'b0, local_set_i = 1'b0;
  logic local_release_i = 1'b0, pulse_src_i = 1'b0, crit_fault_i = 1'b0;
  logic nv_retentive_i = 1'b0, nv_latched_i = 1'b0, nv_remote_i = 1'b0;
  logic solid_state_relay_output_o, relay_state_o, remote_flag_o, latch_flag_o;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int failures = 0, compares = 0, seed = 32'h2baa, rises, falls, hi, lo;
  int n, w, r0, f0;
  logic mst, mrem, mlat, minv;
  relay_output_command_logic #(.MS_CYCLES(8)) i_dut (
    .clk_i, .nrst_i, .sample_tick_i, .local_set_i, .local_release_i, .pulse_src_i,
    .crit_fault_i, .nv_retentive_i, .nv_latched_i, .nv_remote_i,
    .solid_state_relay_output_o, .relay_state_o, .remote_flag_o, .latch_flag_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  relay_far_side i_far (
    .clk_i, .contact_i(solid_state_relay_output_o), .rises_o(rises),
    .falls_o(falls), .hi_o(hi), .lo_o(lo)
  );
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  // one sample every second clock: a scan is 256 clocks
  always @(posedge clk_i) sample_tick_i <= ~sample_tick_i;
  // ==========================================================
  // tasks
  task automatic report_and_stop;
    begin
      if (failures == 0 && compares > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask : report_and_stop
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    begin
      compares++;
      if (got !== exp)
      begin
        failures++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask : cmp
  task automatic cmp_rng(input int got, input int lo_b, input int hi_b);
    begin
      compares++;
      if (got < lo_b || got > hi_b)
      begin
        failures++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo_b);
      end
    end
  endtask : cmp_rng
  task automatic check_relay;
    begin
      cmp(relay_state_o, mst);
      cmp(solid_state_relay_output_o, mst ^ minv);
      cmp(remote_flag_o, mrem);
      cmp(latch_flag_o, mlat);
    end
  endtask : check_relay
  task automatic scan_wait;
    begin
      repeat (SCAN + 6) @(posedge clk_i);
    end
  endtask : scan_wait
  task automatic do_reset;
    begin
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
  endtask : do_reset
  task automatic kick;
    begin
      @(posedge clk_i);
      pulse_src_i <= 1'b1;
      @(posedge clk_i);
      pulse_src_i <= 1'b0;
    end
  endtask : kick
  task automatic wait_edges(input bit up, input int target);
    int k;
    begin
      k = 0;
      while (((up ? rises : falls) < target) && k < 5000)
      begin
        @(posedge clk_i);
        k++;
      end
      if (k >= 5000)
      begin
        failures++;
        report_and_stop();
      end
    end
  endtask : wait_edges
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    begin
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      k = 0;
      do
      begin
        @(posedge clk_i);
        if (s_axi_awvalid && s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready)
          s_axi_wvalid <= 1'b0;
        k++;
      end
      while (s_axi_bvalid !== 1'b1 && k < 200);
      s_axi_bready <= 1'b0;
      if (k >= 200)
      begin
        failures++;
        report_and_stop();
      end
      cmp(s_axi_bresp, er);
    end
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    begin
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      k = 0;
      do
      begin
        @(posedge clk_i);
        if (s_axi_arvalid && s_axi_arready)
          s_axi_arvalid <= 1'b0;
        k++;
      end
      while (s_axi_rvalid !== 1'b1 && k < 200);
      s_axi_rready <= 1'b0;
      if (k >= 200)
      begin
        failures++;
        report_and_stop();
      end
      cmp(s_axi_rdata, ed);
      cmp(s_axi_rresp, er);
    end
  endtask : axi_read
  // ==========================================================
  // sequence
  initial
  begin
    repeat (100000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end
  initial
  begin
    do_reset();
    axi_read(CTRL_OFS, 32'h0, RESP_OKAY);
    axi_read(WIDTH_OFS, {22'h0, WIDTH_RST}, RESP_OKAY);
    axi_read(4'h2, 32'h0, RESP_SLVERR);
    axi_write(STATUS_OFS, 32'hF, RESP_SLVERR);
    axi_write(WIDTH_OFS, 32'h3FF, RESP_OKAY);
    axi_read(WIDTH_OFS, {22'h0, PULSE_MAX_MS}, RESP_OKAY);
    axi_write(WIDTH_OFS, 32'h0, RESP_OKAY);
    axi_read(WIDTH_OFS, {22'h0, PULSE_MIN_MS}, RESP_OKAY);
    {mst, mrem, mlat, minv} = 4'h1;
    axi_write(CTRL_OFS, 32'h4, RESP_OKAY);
    scan_wait();
    check_relay();
    local_set_i <= 1'b1;
    mst = 1'b1;
    scan_wait();
    check_relay();
    local_set_i <= 1'b0;
    mst = 1'b0;
    scan_wait();
    check_relay();
    axi_write(CMD_OFS, 32'h1, RESP_OKAY);
    {mst, mrem} = 2'h3;
    scan_wait();
    check_relay();
    axi_write(CMD_OFS, 32'h2, RESP_OKAY);
    {mst, mrem, minv} = 3'h0;
    scan_wait();
    axi_write(CTRL_OFS, 32'h1, RESP_OKAY);
    local_set_i <= 1'b1;
    scan_wait();
    local_set_i <= 1'b0;
    {mst, mlat} = 2'h3;
    scan_wait();
    check_relay();
    axi_write(CMD_OFS, 32'h1, RESP_OKAY);
    mrem = 1'b1;
    @(posedge clk_i);
    local_release_i <= 1'b1;
    @(posedge clk_i);
    local_release_i <= 1'b0;
    mlat = 1'b0;
    scan_wait();
    check_relay();
    axi_write(CMD_OFS, 32'h2, RESP_OKAY);
    {mst, mrem} = 2'h0;
    scan_wait();
    check_relay();
    local_set_i <= 1'b1;
    scan_wait();
    local_set_i <= 1'b0;
    axi_write(CMD_OFS, 32'h2, RESP_OKAY);
    scan_wait();
    check_relay();
    axi_write(CMD_OFS, 32'h1, RESP_OKAY);
    {mst, mrem} = 2'h3;
    scan_wait();
    check_relay();
    {mst, mrem} = 2'h0;
    crit_fault_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check_relay();
    axi_read(STATUS_OFS, 32'h80, RESP_OKAY);
    crit_fault_i <= 1'b0;
    scan_wait();
    check_relay();
    n = $unsigned($random(seed)) % 3;
    w = 32 * n + 10 + $unsigned($random(seed)) % 20;
    n = n + 1;
    axi_write(WIDTH_OFS, w, RESP_OKAY);
    axi_write(CTRL_OFS, 32'h2, RESP_OKAY);
    r0 = rises;
    f0 = falls;
    kick();
    wait_edges(1'b1, r0 + 1);
    kick();
    wait_edges(1'b0, f0 + 1);
    cmp_rng(hi, n * SCAN, n * SCAN);
    wait_edges(1'b0, f0 + 2);
    cmp_rng(hi, n * SCAN, n * SCAN);
    cmp_rng(lo, n * SCAN, (n + 1) * SCAN);
    axi_write(CMD_OFS, 32'h1, RESP_OKAY);
    wait_edges(1'b0, f0 + 3);
    cmp_rng(hi, n * SCAN, n * SCAN);
    axi_write(CMD_OFS, 32'h2, RESP_OKAY);
    repeat (n + 2) scan_wait();
    cmp(rises, r0 + 3);
    cmp(relay_state_o, 1'b0);
    axi_write(CTRL_OFS, 32'h3, RESP_OKAY);
    r0 = rises;
    f0 = falls;
    kick();
    wait_edges(1'b1, r0 + 1);
    kick();
    wait_edges(1'b0, f0 + 1);
    cmp_rng(hi, n * SCAN, (n + 1) * SCAN);
    axi_write(CMD_OFS, 32'h1, RESP_OKAY);
    wait_edges(1'b1, r0 + 2);
    cmp_rng(lo, n * SCAN, (n + 1) * SCAN);
    axi_write(CMD_OFS, 32'h2, RESP_OKAY);
    repeat (n + 2) scan_wait();
    cmp(relay_state_o, 1'b1);
    kick();
    wait_edges(1'b0, f0 + 2);
    nv_retentive_i <= 1'b1;
    nv_latched_i <= 1'b1;
    nv_remote_i <= 1'b1;
    do_reset();
    {mst, mrem, mlat, minv} = 4'hE;
    scan_wait();
    check_relay();
    nv_retentive_i <= 1'b0;
    do_reset();
    {mst, mrem, mlat} = 3'h0;
    scan_wait();
    check_relay();
    report_and_stop();
  end
endmodule : relay_output_command_logic_tb
